/* bfp_pkg.sv */
// bfp_pkg: shared constants and types for the two-port queue pair and its host
// assumes: nothing beyond a single 10 MHz system clock on both ends
package bfp_pkg;

    // port data width and the packed layout of one port's sampled inputs
    localparam int DATA_W = 36;
    localparam int PORT_IN_W = DATA_W + 4;
    localparam int IN_CLK = 0, IN_SEL_N = 1, IN_QUAL = 2, IN_WR = 3, IN_DATA = 4;
    // idle pin levels: select high, all else low
    localparam logic [PORT_IN_W-1:0] IN_RESET = 40'h0000000002;

    // queue storage and near-flag threshold
    localparam int DEPTH_LOG2 = 4, NEAR_OFFSET = 8;

    // port clock made by the host from the system clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int PORT_CLK_HALF_NS = 1000;
    localparam int PORT_HALF_CYC = (PORT_CLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // host register map, byte addresses
    localparam logic [7:0] REG_CFG = 8'h00, REG_CMD = 8'h04, REG_WDATA_LO = 8'h08, REG_WDATA_HI = 8'h0C;
    localparam logic [7:0] REG_RDATA_LO = 8'h10, REG_RDATA_HI = 8'h14, REG_STATUS = 8'h18;
    localparam int CMD_PORT_BIT = 0, CMD_WRITE_BIT = 1;
    localparam logic CFG_RESET = 1'b1;

    // axi responses
    localparam logic [1:0] AXI_OKAY = 2'h0, AXI_SLVERR = 2'h2;

    // host transfer sequencer
    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_XFER = 5'h02,
        HS_HOLD = 5'h04,
        HS_WAIT = 5'h08,
        HS_DONE = 5'h10
    } bfp_hstate_t;

endpackage

/* bfp_link_if.sv */
// bfp_link_if: pins between the queue device and its host, both ports
// assumes: device and host share clk; data lines resolve from the two enables
`timescale 1ns/1ps
interface bfp_link_if;
    logic port_a_clock, port_b_clock, port_a_select_n, port_b_select_n;
    logic port_a_transfer_qualifier, port_b_transfer_qualifier;
    logic port_a_write_select, port_b_write_select, fall_through_select;
    logic [bfp_pkg::DATA_W-1:0] port_a_data_lines, port_b_data_lines, port_a_data_dev_o, port_b_data_dev_o;
    logic [bfp_pkg::DATA_W-1:0] port_a_data_host_o, port_b_data_host_o;
    logic port_a_data_dev_oe, port_b_data_dev_oe, port_a_data_host_oe, port_b_data_host_oe;
    logic port_a_empty_or_valid_flag, port_b_empty_or_valid_flag;
    logic port_a_full_or_space_flag, port_b_full_or_space_flag;
    logic port_b_near_full_flag, port_b_near_empty_flag;

    // wire level from the enables; an undriven bus reads as zero
    assign port_a_data_lines = port_a_data_dev_oe ? port_a_data_dev_o :
                               (port_a_data_host_oe ? port_a_data_host_o : '0);
    assign port_b_data_lines = port_b_data_dev_oe ? port_b_data_dev_o :
                               (port_b_data_host_oe ? port_b_data_host_o : '0);

    modport device (
        input port_a_clock, port_b_clock, port_a_select_n, port_b_select_n,
        input port_a_transfer_qualifier, port_b_transfer_qualifier,
        input port_a_write_select, port_b_write_select, fall_through_select,
        input port_a_data_lines, port_b_data_lines,
        output port_a_data_dev_o, port_b_data_dev_o, port_a_data_dev_oe, port_b_data_dev_oe,
        output port_a_empty_or_valid_flag, port_b_empty_or_valid_flag,
        output port_a_full_or_space_flag, port_b_full_or_space_flag,
        output port_b_near_full_flag, port_b_near_empty_flag
    );

    modport host (
        output port_a_clock, port_b_clock, port_a_select_n, port_b_select_n,
        output port_a_transfer_qualifier, port_b_transfer_qualifier,
        output port_a_write_select, port_b_write_select, fall_through_select,
        output port_a_data_host_o, port_b_data_host_o, port_a_data_host_oe, port_b_data_host_oe,
        input port_a_data_lines, port_b_data_lines,
        input port_a_empty_or_valid_flag, port_b_empty_or_valid_flag,
        input port_a_full_or_space_flag, port_b_full_or_space_flag,
        input port_b_near_full_flag, port_b_near_empty_flag
    );
endinterface

/* bfp_fifo_host.sv */
// bfp_fifo_host: party outside the queue device, driving both ports
// assumes: software orders single transfers over axi4-lite; one clk with the device
`timescale 1ns/1ps
module bfp_fifo_host #(
    parameter int HALF_CYC = bfp_pkg::PORT_HALF_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    bfp_link_if.host link
);
    localparam int DW = bfp_pkg::DATA_W;
    localparam int HW = 2 * DW + 6;
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    typedef struct packed {
        logic [7:0] div;
        logic pclk;
        bfp_pkg::bfp_hstate_t st;
        logic pend, port, wr;
        logic [1:0] sel_n, qual, wrsel, oe;
        logic [DW-1:0] dat, wdata, rdata;
        logic ft_lvl;
        logic [HW-1:0] s1, s2, s3, filt;
        logic aw_got, w_got;
        logic [7:0] awaddr;
        logic [31:0] axw;
        logic [3:0] strb;
        logic awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [1:0] rresp;
        logic [31:0] axr;
    } bfp_host_state_t;

    bfp_host_state_t q, d;
    logic tick_rise, tick_fall;
    logic [31:0] wmask, merged;
    logic [DW-1:0] rd_lines;

    // next state of the whole host
    always_comb begin
        d = q;
        tick_rise = (q.div == HALF_LAST) & ~q.pclk;
        tick_fall = (q.div == HALF_LAST) & q.pclk;
        wmask = {{8{q.strb[3]}}, {8{q.strb[2]}}, {8{q.strb[1]}}, {8{q.strb[0]}}};
        merged = '0;
        rd_lines = q.port ? q.filt[2*DW-1:DW] : q.filt[DW-1:0];
        // free-running port clocks, both ports coincident
        d.div = (q.div == HALF_LAST) ? 8'h00 : q.div + 8'h01;
        if (q.div == HALF_LAST) begin
            d.pclk = ~q.pclk;
        end
        // three-flop pin samplers; stages two and three must agree
        d.s1 = {link.port_b_near_empty_flag, link.port_b_near_full_flag,
                link.port_b_full_or_space_flag, link.port_b_empty_or_valid_flag,
                link.port_a_full_or_space_flag, link.port_a_empty_or_valid_flag,
                link.port_b_data_lines, link.port_a_data_lines};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = (q.s3 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
        // pins move on the falling port clock, half a period early
        case (q.st)
            bfp_pkg::HS_IDLE: begin
                if (q.pend && tick_fall) begin
                    d.sel_n[q.port] = 1'b0; // RULE3 RULE5
                    d.qual[q.port] = 1'b1; // RULE7 RULE8
                    d.wrsel[q.port] = q.wr;
                    d.oe[q.port] = q.wr;
                    d.dat = q.wdata;
                    d.st = bfp_pkg::HS_XFER;
                end
            end
            bfp_pkg::HS_XFER: begin
                if (tick_rise) begin
                    // fall-through word is already on the lines before the read edge
                    if (~q.ft_lvl && ~q.wr) begin
                        d.rdata = rd_lines;
                    end
                    d.st = bfp_pkg::HS_HOLD;
                end
            end
            bfp_pkg::HS_HOLD: begin
                if (tick_fall) begin
                    d.qual = 2'h0; // RULE7 RULE8
                    d.oe = 2'h0;
                    d.st = bfp_pkg::HS_WAIT;
                end
            end
            bfp_pkg::HS_WAIT: begin
                if (tick_rise) begin
                    if (q.ft_lvl && ~q.wr) begin
                        d.rdata = rd_lines;
                    end
                    d.st = bfp_pkg::HS_DONE;
                end
            end
            bfp_pkg::HS_DONE: begin
                if (tick_fall) begin
                    d.sel_n = 2'h3;
                    d.wrsel = 2'h0;
                    d.pend = 1'b0;
                    d.st = bfp_pkg::HS_IDLE;
                end
            end
            default: begin
                d.st = bfp_pkg::HS_IDLE;
            end
        endcase
        // write address and data taken in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.axw = s_axi_wdata;
            d.strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = bfp_pkg::AXI_OKAY;
            if (q.awaddr == bfp_pkg::REG_CFG) begin
                // level held static by software once traffic starts
                if (q.strb[0]) begin
                    d.ft_lvl = q.axw[0]; // RULE18
                end
            end else if (q.awaddr == bfp_pkg::REG_CMD) begin
                // a command while busy is dropped, never queued
                if (~q.pend && q.strb[0]) begin
                    d.port = q.axw[bfp_pkg::CMD_PORT_BIT];
                    d.wr = q.axw[bfp_pkg::CMD_WRITE_BIT];
                    d.pend = 1'b1;
                end
            end else if (q.awaddr == bfp_pkg::REG_WDATA_LO) begin
                merged = (q.wdata[31:0] & ~wmask) | (q.axw & wmask);
                d.wdata[31:0] = merged;
            end else if (q.awaddr == bfp_pkg::REG_WDATA_HI) begin
                if (q.strb[0]) begin
                    d.wdata[DW-1:32] = q.axw[DW-33:0];
                end
            end else if (q.awaddr == bfp_pkg::REG_RDATA_LO || q.awaddr == bfp_pkg::REG_RDATA_HI
                         || q.awaddr == bfp_pkg::REG_STATUS) begin
                d.bresp = bfp_pkg::AXI_OKAY;
            end else begin
                d.bresp = bfp_pkg::AXI_SLVERR;
            end
        end
        // read channel answers the cycle after the address is taken
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = bfp_pkg::AXI_OKAY;
            if (s_axi_araddr == bfp_pkg::REG_CFG) begin
                d.axr = {31'h00000000, q.ft_lvl};
            end else if (s_axi_araddr == bfp_pkg::REG_CMD) begin
                d.axr = {30'h00000000, q.wr, q.port};
            end else if (s_axi_araddr == bfp_pkg::REG_WDATA_LO) begin
                d.axr = q.wdata[31:0];
            end else if (s_axi_araddr == bfp_pkg::REG_WDATA_HI) begin
                d.axr = {28'h0000000, q.wdata[DW-1:32]};
            end else if (s_axi_araddr == bfp_pkg::REG_RDATA_LO) begin
                d.axr = q.rdata[31:0];
            end else if (s_axi_araddr == bfp_pkg::REG_RDATA_HI) begin
                d.axr = {28'h0000000, q.rdata[DW-1:32]};
            end else if (s_axi_araddr == bfp_pkg::REG_STATUS) begin
                d.axr = {25'h0000000, q.filt[HW-1:2*DW], q.pend};
            end else begin
                d.axr = 32'h00000000;
                d.rresp = bfp_pkg::AXI_SLVERR;
            end
        end
        d.awready = ~d.aw_got & ~d.bvalid;
        d.wready = ~d.w_got & ~d.bvalid;
        d.arready = ~d.rvalid;
    end

    // single state register, constants only under reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= bfp_pkg::HS_IDLE;
            q.sel_n <= 2'h3;
            q.ft_lvl <= bfp_pkg::CFG_RESET;
        end else begin
            q <= d;
        end
    end

    assign link.port_a_clock = q.pclk; // RULE19
    assign link.port_b_clock = q.pclk;
    assign link.port_a_select_n = q.sel_n[0];
    assign link.port_b_select_n = q.sel_n[1];
    assign link.port_a_transfer_qualifier = q.qual[0];
    assign link.port_b_transfer_qualifier = q.qual[1];
    assign link.port_a_write_select = q.wrsel[0];
    assign link.port_b_write_select = q.wrsel[1];
    assign link.fall_through_select = q.ft_lvl; // RULE18
    assign link.port_a_data_host_o = q.dat;
    assign link.port_b_data_host_o = q.dat;
    assign link.port_a_data_host_oe = q.oe[0];
    assign link.port_b_data_host_oe = q.oe[1];
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.axr;
endmodule

/* bfp_fifo_dev.sv */
// bfp_fifo_dev: device end, two opposite queues with per-port control and flags
// assumes: port pins arrive asynchronous to clk and are oversampled; host idles select high
//
// Summary of operation
// [RULE1] port b transfers timed by port b clock
// [RULE2] port b flags change only on b edges
// [RULE3] port a transfers need select low
// [RULE4] port a lines released while select high
// [RULE5] port b transfers need select low
// [RULE6] port b lines released while select high
// [RULE7] port a edge transfers only when qualified
// [RULE8] port b edge transfers only when qualified
// [RULE9] standard mode: port a flag shows b-to-a empty
// [RULE10] fall-through: port a flag shows word presented
// [RULE11] standard mode: port b flag shows a-to-b empty
// [RULE12] fall-through: port b flag shows word presented
// [RULE13] standard mode: port a full flag for a-to-b
// [RULE14] fall-through: port a space flag for a-to-b
// [RULE15] standard mode: port b full flag for b-to-a
// [RULE16] fall-through: port b space flag for b-to-a
// [RULE17] port a flags change only on a edges
// [RULE18] host sets timing mode, holds it static
// [RULE19] port a transfers timed by port a clock
// [RULE20] write when full, read when empty ignored
`timescale 1ns/1ps
module bfp_fifo_dev #(
    parameter int DEPTH_LOG2 = bfp_pkg::DEPTH_LOG2,
    parameter int NEAR_OFFSET = bfp_pkg::NEAR_OFFSET
) (
    input wire logic clk,
    input wire logic resetn,
    bfp_link_if.device link
);
    localparam int DW = bfp_pkg::DATA_W;
    localparam int IW = bfp_pkg::PORT_IN_W;
    localparam int DEPTH = 1 << DEPTH_LOG2;
    localparam logic [DEPTH_LOG2:0] FULL_CNT = (DEPTH_LOG2 + 1)'(DEPTH);
    localparam logic [DEPTH_LOG2:0] NEAR_CNT = (DEPTH_LOG2 + 1)'(NEAR_OFFSET);
    localparam logic [DEPTH_LOG2:0] ZERO_CNT = '0;

    // index 0 is port a / the a-to-b queue, index 1 is port b / the b-to-a queue
    typedef struct packed {
        logic [1:0][IW-1:0] s1;
        logic [1:0][IW-1:0] s2;
        logic [1:0][IW-1:0] s3;
        logic [1:0][IW-1:0] filt;
        logic [2:0] fts;
        logic ft_lvl;
        logic [1:0][DEPTH-1:0][DW-1:0] mem;
        logic [1:0][DEPTH_LOG2-1:0] wptr;
        logic [1:0][DEPTH_LOG2-1:0] rptr;
        logic [1:0][DEPTH_LOG2:0] cnt;
        logic [1:0][DW-1:0] oreg;
        logic [1:0] ovalid;
        logic [1:0] oe;
        logic [1:0] ef;
        logic [1:0] ff;
        logic near_full_b;
        logic near_empty_b;
    } bfp_dev_state_t;

    bfp_dev_state_t q, d;
    logic ft;
    logic [1:0] edge_seen;
    logic [1:0] go;
    logic [1:0] wr_ok;
    logic [1:0] rd_ok;
    logic [1:0] ld;

    // next state of the whole device
    always_comb begin
        d = q;
        edge_seen = '0;
        go = '0;
        wr_ok = '0;
        rd_ok = '0;
        ld = '0;

        // three-flop sampling of every port pin
        d.s1[0] = {link.port_a_data_lines, link.port_a_write_select,
                   link.port_a_transfer_qualifier, link.port_a_select_n, link.port_a_clock};
        d.s1[1] = {link.port_b_data_lines, link.port_b_write_select,
                   link.port_b_transfer_qualifier, link.port_b_select_n, link.port_b_clock};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.fts = {q.fts[1:0], link.fall_through_select};
        if (q.fts[1] == q.fts[2]) begin
            d.ft_lvl = q.fts[2];
        end
        // low on the select pin means fall-through timing
        ft = ~q.ft_lvl;

        // per port: edge detect and qualification of the transfer
        for (int p = 0; p < 2; p++) begin
            d.filt[p] = (q.s3[p] & ~(q.s2[p] ^ q.s3[p])) | (q.filt[p] & (q.s2[p] ^ q.s3[p]));
            // a rising port clock counts once stages two and three agree high
            edge_seen[p] = q.s2[p][bfp_pkg::IN_CLK] & q.s3[p][bfp_pkg::IN_CLK]
                           & ~q.filt[p][bfp_pkg::IN_CLK]; // RULE1 RULE19
            // controls were set half a port period earlier, so stage three is settled
            go[p] = edge_seen[p] & ~q.s3[p][bfp_pkg::IN_SEL_N] // RULE3 RULE5
                    & q.s3[p][bfp_pkg::IN_QUAL]; // RULE7 RULE8
            wr_ok[p] = go[p] & q.s3[p][bfp_pkg::IN_WR] & (q.cnt[p] != FULL_CNT); // RULE20
            rd_ok[p] = go[p] & ~q.s3[p][bfp_pkg::IN_WR]
                       & (ft ? q.ovalid[1-p] : (q.cnt[1-p] != ZERO_CNT)); // RULE20
        end

        // per queue: filled from port k, drained by the opposite port
        for (int k = 0; k < 2; k++) begin
            // fall-through refills the output word on its own; standard loads only on a read
            ld[k] = (q.cnt[k] != ZERO_CNT) & (ft ? (~q.ovalid[k] | rd_ok[1-k]) : rd_ok[1-k]);
            if (wr_ok[k]) begin
                d.mem[k][q.wptr[k]] = q.s3[k][bfp_pkg::IN_DATA +: DW];
                d.wptr[k] = q.wptr[k] + 1'b1;
            end
            if (ld[k]) begin
                d.oreg[k] = q.mem[k][q.rptr[k]];
                d.rptr[k] = q.rptr[k] + 1'b1;
                d.ovalid[k] = 1'b1;
            end else if (rd_ok[1-k]) begin
                // last word taken, nothing behind it
                d.ovalid[k] = 1'b0;
            end
            d.cnt[k] = q.cnt[k] + {{DEPTH_LOG2{1'b0}}, wr_ok[k]} - {{DEPTH_LOG2{1'b0}}, ld[k]};
        end

        // flags of a port move only with that port's own rising clock
        for (int p = 0; p < 2; p++) begin
            if (edge_seen[p]) begin // RULE2 RULE17
                // output flag watches the queue this port drains
                d.ef[p] = ft ? d.ovalid[1-p] // RULE10 RULE12
                          : (d.cnt[1-p] == ZERO_CNT); // RULE9 RULE11
                // input flag watches the queue this port fills
                d.ff[p] = ft ? (d.cnt[p] != FULL_CNT) // RULE14 RULE16
                          : (d.cnt[p] == FULL_CNT); // RULE13 RULE15
            end
            // drive lines only for a selected read; the host owns them on writes
            d.oe[p] = ~d.filt[p][bfp_pkg::IN_SEL_N] & ~d.filt[p][bfp_pkg::IN_WR]; // RULE4 RULE6
        end

        // port b near flags: fill of a-to-b, free room of b-to-a
        if (edge_seen[1]) begin // RULE2
            d.near_empty_b = d.cnt[0] <= NEAR_CNT;
            d.near_full_b = (FULL_CNT - d.cnt[1]) <= NEAR_CNT;
        end
    end

    // single state register; idle pin levels and standard-mode flags under reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.s1 <= {2{bfp_pkg::IN_RESET}};
            q.s2 <= {2{bfp_pkg::IN_RESET}};
            q.s3 <= {2{bfp_pkg::IN_RESET}};
            q.filt <= {2{bfp_pkg::IN_RESET}};
            q.fts <= 3'h7;
            q.ft_lvl <= 1'b1;
            q.ef <= 2'h3;
            q.near_empty_b <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // the output word of the opposite queue faces each port
    assign link.port_a_data_dev_o = q.oreg[1];
    assign link.port_b_data_dev_o = q.oreg[0];
    assign link.port_a_data_dev_oe = q.oe[0];
    assign link.port_b_data_dev_oe = q.oe[1];
    assign link.port_a_empty_or_valid_flag = q.ef[0];
    assign link.port_b_empty_or_valid_flag = q.ef[1];
    assign link.port_a_full_or_space_flag = q.ff[0];
    assign link.port_b_full_or_space_flag = q.ff[1];
    assign link.port_b_near_full_flag = q.near_full_b;
    assign link.port_b_near_empty_flag = q.near_empty_b;
endmodule

/* bfp_chk.sv */
// bfp_chk: timing checks on the link between queue device and host
// assumes: both ends on clk; inputs are the link signals themselves
`timescale 1ns/1ps
module bfp_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_a_clock,
    input wire logic port_b_clock,
    input wire logic port_a_select_n,
    input wire logic port_b_select_n,
    input wire logic fall_through_select,
    input wire logic port_a_data_dev_oe,
    input wire logic port_b_data_dev_oe,
    input wire logic port_a_empty_or_valid_flag,
    input wire logic port_a_full_or_space_flag,
    input wire logic port_b_empty_or_valid_flag,
    input wire logic port_b_full_or_space_flag,
    input wire logic port_b_near_empty_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // select held high long enough for the pin samplers to follow
    sequence a_idle; port_a_select_n [*8]; endsequence
    sequence b_idle; port_b_select_n [*8]; endsequence
    // a sampled port edge lands while its clock pin is still high
    sequence a_edge; $past(port_a_clock, 2); endsequence
    sequence b_edge; $past(port_b_clock, 2); endsequence
    AST_A_RELEASE: assert property (a_idle |-> !port_a_data_dev_oe) else $error("a lines driven");
    AST_B_RELEASE: assert property (b_idle |-> !port_b_data_dev_oe) else $error("b lines driven");
    AST_A_DRIVE_SEL: assert property ($rose(port_a_data_dev_oe) |-> !$past(port_a_select_n, 3))
        else $error("a drive unselected");
    AST_B_DRIVE_SEL: assert property ($rose(port_b_data_dev_oe) |-> !$past(port_b_select_n, 3))
        else $error("b drive unselected");
    AST_A_FLAG_EDGE: assert property ($changed({port_a_empty_or_valid_flag, port_a_full_or_space_flag})
        |-> a_edge) else $error("a flag off edge");
    AST_B_FLAG_EDGE: assert property ($changed({port_b_empty_or_valid_flag, port_b_full_or_space_flag,
        port_b_near_empty_flag}) |-> b_edge) else $error("b flag off edge");
    // in standard mode a queue cannot be empty while full or while above the near-empty mark, whatever the sampling lag
    AST_STD_FULL: assert property (fall_through_select && port_b_empty_or_valid_flag
        |-> !port_a_full_or_space_flag) else $error("full with empty");
    AST_STD_NEAR: assert property (fall_through_select && !port_b_near_empty_flag
        |-> !port_b_empty_or_valid_flag) else $error("empty with words");
endmodule

/* testbench.sv */
// testbench: host and queue device joined by the link, software over axi4-lite
// assumes: host half period 10 clk; expected words follow the flag meanings
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [33:0] exp_q[$];
    logic [35:0] wd[17];
    int miscompares = 0, n_compared = 0;
    bfp_link_if l();
    always #50 clk = ~clk;
    bfp_fifo_dev bfp_fifo_dev_i (.clk, .resetn, .link(l.device));
    bfp_fifo_host #(.HALF_CYC(10)) bfp_fifo_host_i (.clk, .resetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(l.host));
    bfp_chk bfp_chk_i (.clk, .resetn, .port_a_clock(l.port_a_clock), .port_b_clock(l.port_b_clock),
        .port_a_select_n(l.port_a_select_n), .port_b_select_n(l.port_b_select_n),
        .fall_through_select(l.fall_through_select), .port_a_data_dev_oe(l.port_a_data_dev_oe),
        .port_b_data_dev_oe(l.port_b_data_dev_oe), .port_a_empty_or_valid_flag(l.port_a_empty_or_valid_flag),
        .port_a_full_or_space_flag(l.port_a_full_or_space_flag),
        .port_b_empty_or_valid_flag(l.port_b_empty_or_valid_flag),
        .port_b_full_or_space_flag(l.port_b_full_or_space_flag), .port_b_near_empty_flag(l.port_b_near_empty_flag));
    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] ex);
        n_compared++;
        if (seen !== ex) begin
            $display("unexpected %s expected %h seen %h", nm, ex, seen);
            miscompares++;
        end
    endtask
    // one bus access; a late answer ends the run rather than hanging it
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        exp_q.push_back(e);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if ((bvalid && bready) || (rvalid && rready)) break;
        end
        if (!((bvalid && bready) || (rvalid && rready))) begin
            miscompares++;
            end_of_test();
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, {bfp_pkg::AXI_OKAY, 32'h0});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, {bfp_pkg::AXI_OKAY, e});
    endtask
    // one word over the link; the wait covers launch and both port periods
    task automatic link(input logic p, input logic w, input logic [35:0] v);
        wr(bfp_pkg::REG_WDATA_LO, v[31:0]);
        wr(bfp_pkg::REG_WDATA_HI, {28'h0, v[35:32]});
        wr(bfp_pkg::REG_CMD, {30'h0, w, p});
        repeat (70) @(posedge clk);
    endtask
    task automatic rw(input logic [35:0] e);
        rd(bfp_pkg::REG_RDATA_LO, e[31:0]);
        rd(bfp_pkg::REG_RDATA_HI, {28'h0, e[35:32]});
    endtask
    // answers come back in order, so the oldest note is the one to compare
    always @(posedge clk) begin
        if (bvalid && bready) chk("bresp", {bresp, 32'h0}, exp_q.pop_front());
        if (rvalid && rready) chk("rdata", {rresp, rdata}, exp_q.pop_front());
    end
    initial begin
        void'($urandom(77));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(bfp_pkg::REG_CFG, 32'h1);
        bus(1'b1, 8'hFC, 32'h0, {bfp_pkg::AXI_SLVERR, 32'h0});
        bus(1'b0, 8'hFC, 32'h0, {bfp_pkg::AXI_SLVERR, 32'h0});
        repeat (70) @(posedge clk);
        rd(bfp_pkg::REG_STATUS, 32'h4A);
        // seventeen words into a sixteen-deep queue: the last is dropped
        for (int i = 0; i < 17; i++) begin
            wd[i] = {i[3:0], $urandom()};
            link(1'b0, 1'b1, wd[i]);
        end
        rd(bfp_pkg::REG_STATUS, 32'h06);
        // the extra read finds it empty and leaves the last capture alone
        for (int i = 0; i < 17; i++) begin
            link(1'b1, 1'b0, 36'h0);
            rw(wd[i < 16 ? i : 15]);
        end
        rd(bfp_pkg::REG_STATUS, 32'h4A);
        wd[0] = {4'hA, $urandom()};
        link(1'b1, 1'b1, wd[0]);
        rd(bfp_pkg::REG_STATUS, 32'h48);
        link(1'b0, 1'b0, 36'h0);
        rw(wd[0]);
        // a word left behind by the reset must not reappear
        link(1'b0, 1'b1, 36'h123456789);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        wr(bfp_pkg::REG_CFG, 32'h0);
        wd[1] = {4'h5, $urandom()};
        link(1'b0, 1'b1, wd[1]);
        rd(bfp_pkg::REG_STATUS, 32'h5C);
        link(1'b1, 1'b0, 36'h0);
        rw(wd[1]);
        rd(bfp_pkg::REG_STATUS, 32'h54);
        end_of_test();
    end
endmodule
